// >>> verilog/bsd_pkg.sv
// bsd_pkg: shared widths, limits and reset values for the symbol decoder.
// assumes one sample clock, with every slower rate carried by an enable.
package bsd_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned SYM_LEN_MAX = 65535;
  localparam int unsigned SYM_LEN_DEF = 100;

  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] MAG_RST = 16'h0000;
  localparam logic BIT_RST = 1'b0;
  localparam logic VAL_RST = 1'b0;

  // everything the decoder hands downstream, kept together
  typedef struct packed {
    logic signed [DATA_W-1:0] mag;
    logic bit_val;
    logic bit_out;
  } bsd_out_t;

  localparam bsd_out_t OUT_RST = '{mag: MAG_RST, bit_val: VAL_RST, bit_out: BIT_RST};

endpackage : bsd_pkg

// >>> verilog/bsd_symbol_decoder.sv
// bsd_symbol_decoder: symbol timing recovery and bit decisions on the
// shaped output of a phase-shift-keying demodulator.
// assumes shaped_in and decision_level come from logic on core_clk, so no
// synchronisers; clk_en qualifies every edge for inputs and outputs alike.
`timescale 1ns/10ps
`default_nettype none

// Function
// R1 - symbol length is a build parameter, fixed while running
// R2 - symbol length counts whole sample clocks and paces symbol timing
// R3 - decision level may change any time, applied without reset
// R4 - shaped signal compared against the decision level as relative amplitude
// R5 - lower level accepts weaker symbols, higher level accepts fewer
// R6 - shaped amplitude output is the filter sample, signed 16-bit, unprocessed
// R7 - inputs and outputs act only on enabled rising edges
// R8 - bit output meaningful only while the valid strobe is high
// R9 - enable low stalls the whole pipeline, no loss or duplication
// R10 - controller should set level near 2 to 5 percent of peak
// R11 - symbol length parameter accepts 0 to 65535
// R12 - build option inverts every decided symbol
// R13 - decision level is a 16-bit unsigned quantity
// R14 - reset clears timing counter, valid low, bit zero
// R15 - at sample point, above level gives one, below negative gives zero
module bsd_symbol_decoder
  import bsd_pkg::*;
#(
  parameter int unsigned SYM_LEN = SYM_LEN_DEF,
  parameter bit INVERT = 1'b0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic signed [DATA_W-1:0] shaped_in,
  input wire logic [DATA_W-1:0] decision_level,
  output logic signed [DATA_W-1:0] shaped_mag,
  output logic bit_valid,
  output logic bit_out
);

  // a zero or one cycle symbol degenerates to deciding on every sample
  localparam int unsigned EFF_LEN = (SYM_LEN < 1) ? 1 : SYM_LEN;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(EFF_LEN - 1); // see R1 see R2
  localparam logic [CNT_W-1:0] CNT_MID = CNT_W'((EFF_LEN - 1) / 2);

  generate
    if (SYM_LEN > SYM_LEN_MAX) begin : g_len_check
      $error("symbol length beyond the counter range"); // see R11
    end
    // the counter must reach the longest legal symbol without wrapping early
    if (SYM_LEN_MAX >= (64'd1 << CNT_W)) begin : g_cnt_check
      $error("symbol counter too narrow for the longest symbol"); // see R11
    end
    if (DATA_W < 2) begin : g_data_check
      $error("sample width too small for a sign and a magnitude"); // see R6
    end
  endgenerate

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic sign_q;
  bsd_out_t out_q;
  bsd_out_t out_d;

  wire logic signed [DATA_W:0] sample_ext = {shaped_in[DATA_W-1], shaped_in};
  // unsigned level widened with a zero sign bit, so it is never negative
  wire logic signed [DATA_W:0] level_pos = {1'b0, decision_level}; // see R13
  wire logic signed [DATA_W:0] level_neg = -level_pos;
  wire logic pos_hit = sample_ext >= level_pos; // see R4 see R5
  wire logic neg_hit = sample_ext <= level_neg; // see R4 see R5
  // resync on a sign change; noise near zero can jitter timing, a known limit
  wire logic crossing = shaped_in[DATA_W-1] != sign_q;
  wire logic at_last = cnt_q == CNT_LAST;
  wire logic sample_pt = cnt_q == CNT_MID;
  // positive side wins when a zero level makes both true
  wire logic decide = sample_pt && (pos_hit || neg_hit); // see R15
  wire logic raw_bit = pos_hit;
  wire logic dec_bit = INVERT ? !raw_bit : raw_bit; // see R12

  assign cnt_d = (crossing || at_last) ? CNT_RST : cnt_q + CNT_W'(1); // see R2

  always_comb begin
    out_d = out_q;
    out_d.mag = shaped_in; // see R6
    out_d.bit_val = decide; // see R8 see R15
    if (decide) begin
      out_d.bit_out = dec_bit;
    end
  end

  // level read live each enabled edge, nothing latched from it
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cnt_q <= CNT_RST; // see R14
      sign_q <= 1'b0;
      out_q <= OUT_RST; // see R14
    end else if (clk_en) begin // see R7 see R9 see R3
      cnt_q <= cnt_d;
      sign_q <= shaped_in[DATA_W-1];
      out_q <= out_d;
    end
  end

  assign shaped_mag = out_q.mag;
  assign bit_valid = out_q.bit_val;
  assign bit_out = out_q.bit_out;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_one_seen;
    clk_en && decide && pos_hit;
  endsequence

  sequence s_zero_seen;
    clk_en && decide && !pos_hit;
  endsequence

  a_reset_clears_out: assert property (disable iff (1'b0) // see R14
    !resetn |=> !bit_valid && !bit_out && cnt_q == CNT_RST)
    else $error("reset did not clear counter and outputs");

  a_stall_holds_all: assert property ( // see R9
    !clk_en |=> $stable(bit_valid) && $stable(bit_out) && $stable(shaped_mag)
      && $stable(cnt_q))
    else $error("state moved while enable was low");

  a_mag_passes_through: assert property ( // see R6
    clk_en |=> shaped_mag == $past(shaped_in))
    else $error("shaped amplitude output is not the filter sample");

  a_one_decision_made: assert property ( // see R15
    s_one_seen |=> bit_valid && bit_out == !INVERT)
    else $error("sample above level did not give a one");

  a_zero_decision_made: assert property ( // see R12
    s_zero_seen |=> bit_valid && bit_out == INVERT)
    else $error("sample below negative level did not give a zero");

  a_no_decision_quiet: assert property ( // see R5
    clk_en && !decide |=> !bit_valid && $stable(bit_out))
    else $error("valid raised without a decision");

  a_valid_single_pulse: assert property ( // see R8
    clk_en && bit_valid && EFF_LEN > 1 |=> !bit_valid)
    else $error("valid strobe held for more than one enabled cycle");

  a_cnt_in_range: assert property ( // see R2
    cnt_q <= CNT_LAST)
    else $error("symbol counter passed the symbol length");

  a_cnt_advances: assert property ( // see R2
    clk_en && !crossing && !at_last |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("symbol counter did not advance");

  // independent of the compare wires, so a broken comparator shows up here
  sequence s_sample_pt;
    clk_en && sample_pt;
  endsequence

  sequence s_wrap_edge;
    clk_en && at_last && !crossing;
  endsequence

  sequence s_resync_edge;
    clk_en && crossing;
  endsequence

  a_wrap_to_zero: assert property ( // see R2
    s_wrap_edge
      |=> cnt_q == CNT_RST)
    else $error("symbol counter did not wrap at the symbol end");

  a_resync_to_zero: assert property ( // see R2
    s_resync_edge
      |=> cnt_q == CNT_RST)
    else $error("sign change did not restart symbol timing");

  a_decide_mid_only: assert property ( // see R15
    clk_en && !sample_pt
      |=> !bit_valid)
    else $error("decision made away from the sample point");

  a_level_pos_hit: assert property ( // see R3
    s_sample_pt ##0 (!shaped_in[DATA_W-1] && {1'b0, shaped_in[DATA_W-2:0]} >= decision_level)
      |=> bit_valid && bit_out == !INVERT)
    else $error("sample at or above current level gave no one");

  a_level_pos_miss: assert property ( // see R5
    s_sample_pt ##0 (!shaped_in[DATA_W-1] && {1'b0, shaped_in[DATA_W-2:0]} < decision_level)
      |=> !bit_valid && $stable(bit_out))
    else $error("sample below current level gave a decision");

  a_level_neg_hit: assert property ( // see R4
    s_sample_pt ##0 (shaped_in[DATA_W-1] && (shaped_in + $signed({1'b0, decision_level})) <= 0)
      |=> bit_valid && bit_out == INVERT)
    else $error("sample at or below negative level gave no zero");

  a_level_neg_miss: assert property ( // see R5
    s_sample_pt ##0 (shaped_in[DATA_W-1] && (shaped_in + $signed({1'b0, decision_level})) > 0)
      |=> !bit_valid)
    else $error("weak negative sample gave a decision");

  a_stall_holds_sign: assert property ( // see R9
    !clk_en
      |=> $stable(sign_q))
    else $error("sign memory moved while enable was low");

  a_sign_follows: assert property ( // see R2
    clk_en
      |=> sign_q == $past(shaped_in[DATA_W-1]))
    else $error("sign memory does not follow the last enabled sample");

  a_valid_from_mid: assert property ( // see R15
    $rose(bit_valid)
      |-> $past(sample_pt) && $past(clk_en))
    else $error("valid rose without a sample point before it");

  a_reset_clears_mag: assert property (disable iff (1'b0) // see R14
    !resetn
      |=> shaped_mag == MAG_RST && sign_q == 1'b0)
    else $error("reset did not clear amplitude and sign memory");

endmodule : bsd_symbol_decoder
`default_nettype wire

// >>> dv/bsd_src_model.sv
// bsd_src_model: upstream shaped-sample source with optional stalls.
// assumes one core_clk; drives only at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module bsd_src_model
  import bsd_pkg::*;
(
  input wire logic core_clk,
  input wire logic signed [DATA_W-1:0] amp,
  input wire logic stall,
  output logic signed [DATA_W-1:0] shaped_in,
  output logic clk_en
);
  initial shaped_in = '0;
  initial clk_en = 1'b1;
  // a stall drops the enable every other edge, the worst case for the pipeline
  always @(negedge core_clk) begin
    clk_en <= stall ? ~clk_en : 1'b1;
    shaped_in <= amp;
  end
endmodule : bsd_src_model
`default_nettype wire

// >>> dv/bsd_symbol_decoder_tb_top.sv
// bsd_symbol_decoder_tb_top: self-checking bench for the symbol decoder.
// assumes SYM_LEN=4, so one decision in every 4 enabled edges while the sample sign holds.
`timescale 1ns/10ps
`default_nettype none
module bsd_symbol_decoder_tb_top;
  import bsd_pkg::*;
  logic core_clk, resetn, stall, en, bv, bo, bvi, boi;
  logic signed [DATA_W-1:0] amp, x, mag;
  logic [DATA_W-1:0] lvl;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int p;
  bsd_src_model u_bsd_src_model (.core_clk(core_clk), .amp(amp), .stall(stall),
    .shaped_in(x), .clk_en(en));
  bsd_symbol_decoder #(.SYM_LEN(4)) u_bsd_symbol_decoder (.core_clk(core_clk),
    .resetn(resetn), .clk_en(en), .shaped_in(x), .decision_level(lvl),
    .shaped_mag(mag), .bit_valid(bv), .bit_out(bo));
  bsd_symbol_decoder #(.SYM_LEN(4), .INVERT(1'b1)) u_bsd_symbol_decoder_inv (
    .core_clk(core_clk), .resetn(resetn), .clk_en(en), .shaped_in(x),
    .decision_level(lvl), .shaped_mag(), .bit_valid(bvi), .bit_out(boi));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input logic c);
    checks_done++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t output mismatch", $time);
    end
  endtask : chk
  // first 4 enabled edges are settling time after an input change, not counted
  task automatic run(input logic signed [DATA_W-1:0] a, input logic [DATA_W-1:0] l,
                     input logic s, input logic e);
    logic [DATA_W+1:0] prev;
    int k;
    k = 0;
    p = 0;
    prev = {mag, bv, bo};
    amp <= a;
    lvl <= l;
    stall <= s;
    while (k < 20) begin
      @(negedge core_clk);
      if (en) begin
        k++;
        if (bv && k > 4) begin
          p++;
          chk(bo === e);
          chk(bvi === 1'b1 && boi === ~e);
        end
      end else
        chk({mag, bv, bo} === prev);
      prev = {mag, bv, bo};
    end
  endtask : run
  task automatic t_reset();
    chk(mag === MAG_RST && bv === VAL_RST && bo === BIT_RST);
  endtask : t_reset
  task automatic t_polarity();
    run(16'sh01F4, 16'h0064, 1'b0, 1'b1);
    chk(p === 4 && mag === 16'sh01F4);
    run(-16'sh01F4, 16'h0064, 1'b0, 1'b0);
    chk(p === 4 && mag === -16'sh01F4);
  endtask : t_polarity
  task automatic t_level();
    run(16'sh0032, 16'h0033, 1'b0, 1'b1);
    chk(p === 0);
    run(16'sh0032, 16'h0032, 1'b0, 1'b1);
    chk(p === 4);
    run(-16'sh01F4, 16'hC000, 1'b0, 1'b0);
    chk(p === 0);
    run(16'sh01F4, 16'h000A, 1'b0, 1'b1);
    chk(p === 4);
  endtask : t_level
  task automatic t_midreset();
    resetn <= 1'b0;
    repeat (2) @(negedge core_clk);
    t_reset();
    resetn <= 1'b1;
    run(-16'sh01F4, 16'h0064, 1'b0, 1'b0);
    chk(p === 4 && mag === -16'sh01F4);
  endtask : t_midreset
  task automatic t_stall();
    run(16'sh01F4, 16'h0064, 1'b1, 1'b1);
    chk(p === 4);
  endtask : t_stall
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    resetn = 1'b0;
    amp = '0;
    lvl = '0;
    stall = 1'b0;
    repeat (12) @(negedge core_clk);
    t_reset();
    resetn <= 1'b1;
    t_polarity();
    t_level();
    t_stall();
    t_midreset();
    finish_test();
  end
endmodule : bsd_symbol_decoder_tb_top
`default_nettype wire
